// File: include/lspcb_pkg.sv
package lspcb_pkg;

    localparam int ADDR_W = 12;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_FILTER_GAIN = 8'h69;
    localparam logic [7:0] IDX_THERM_SS = 8'h6A;
    localparam logic [7:0] IDX_DIV_UPPER = 8'h6B;
    localparam logic [7:0] IDX_SYNC_CTRL = 8'h6C;
    localparam logic [7:0] IDX_LOOP_CFG = 8'h6D;
    localparam logic [7:0] IDX_SYNC_TYPE = 8'h6E;
    localparam logic [7:0] IDX_STATUS = 8'h7F;

    localparam logic [7:0] RST_FILTER_GAIN = 8'h00;
    localparam logic [7:0] RST_THERM_SS = 8'h00;
    localparam logic [7:0] RST_DIV_UPPER = 8'h00;
    localparam logic [7:0] RST_SYNC_CTRL = 8'h00;
    localparam logic [7:0] RST_LOOP_CFG = 8'h00;
    localparam logic [7:0] RST_SYNC_TYPE = 8'h00;

    localparam int GAIN_LSB = 4;
    localparam int FILT_LSB = 0;
    localparam int THERM_EN_BIT = 7;
    localparam int SS_LSB = 4;
    localparam int SYNC_TYPE_BIT = 4;
    localparam int DIV_LOW_W = 5;
    localparam int DIV_W = 13;

    localparam int CLK_KHZ = 25000;
    localparam int SS_MS [4] = '{5, 10, 20, 50};
    localparam int SS_CNT_W = 21;

    localparam int FILT_W = 9;
    localparam logic [8:0] FILT_LEN [16] = '{
        9'h005, 9'h00A, 9'h014, 9'h028, 9'h03C, 9'h050, 9'h064, 9'h08C,
        9'h0B4, 9'h0DC, 9'h104, 9'h12C, 9'h154, 9'h17C, 9'h1A4, 9'h1CC};

    localparam logic [7:0] COEFF_BASE = 8'h10;

    typedef struct packed {
        logic enable;
        logic lock;
        logic cnt_reset;
        logic [4:0] div_low;
    } lspcb_sync_ctrl_type;

    typedef struct packed {
        logic [1:0] coeff_sel;
        logic div_fast;
        logic loop_en;
        logic [3:0] prediv;
    } lspcb_loop_cfg_type;

    typedef enum logic [1:0] {
        SRC_OSC,
        SRC_LOOP_OSC,
        SRC_LOOP_SYNC
    } lspcb_clk_src_type;

endpackage : lspcb_pkg

// File: hw/lspcb_filter.sv
`timescale 1ns/100ps
module lspcb_filter #(
    parameter int LEN_W = 9
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic raw,
    input wire logic [LEN_W-1:0] len,
    output logic filtered_q
);
    logic cand_q;
    logic [LEN_W-1:0] cnt_q;
    wire logic changed = raw != cand_q;
    wire logic len_met = cnt_q >= len;

    // A changed input restarts the count; its first cycle counts as one.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cand_q <= 1'b0;
            cnt_q <= '0;
            filtered_q <= 1'b0;
        end else begin
            cand_q <= raw;
            if (changed) begin
                cnt_q <= LEN_W'(1); // RULE17
            end else if (!len_met) begin
                cnt_q <= cnt_q + LEN_W'(1);
            end
            if (!changed && len_met) begin
                filtered_q <= cand_q; // RULE17
            end
        end
    end

    a_filter_restart: assert property ( // RULE17
        @(posedge clk) disable iff (rst)
        changed |=> cnt_q == LEN_W'(1))
        else $error("filter count did not restart on change");

    a_filter_settle: assert property ( // RULE17
        @(posedge clk) disable iff (rst)
        $changed(filtered_q) |-> $past(len_met) && !$past(changed))
        else $error("filtered output moved before input settled");

endmodule : lspcb_filter

// File: hw/lspcb_top.sv
// Our own choice: the APB interface to the registers.
`timescale 1ns/100ps
// Function
// RULE1: Filter headroom comparator for a 4-bit-selected number of cycles.
// RULE2: Short-string check and boost step-down use only the filtered result.
// RULE3: Hold 4-bit thermal dimming gain in upper nibble of filter register.
// RULE4: Apply thermal current dimming only while its enable bit is set.
// RULE5: Soft-start time from 2-bit code: 5, 10, 20 or 50 ms.
// RULE6: Upper eight divider bits come from their own register.
// RULE7: Lower five divider bits come from sync control bits 4 to 0.
// RULE8: Frame-sync input is ignored unless its enable bit is set.
// RULE9: Lock bit divides dimming output by divider to feed phase detector.
// RULE10: Counter-reset bit resets dimming counter on each frame-sync rise.
// RULE11: Two-bit coefficient code selects 16, 32, 64 or 128.
// RULE12: Divider select: 0 slow with external compensation, 1 fast internal.
// RULE13: Loop off clocks dimming from oscillator; on, via loop.
// RULE14: Pre-divide frame-sync by 1 to 16 from a 4-bit field.
// RULE15: Sync type bit: 0 line-rate signal, 1 frame-rate signal.
// RULE16: The 13-bit divider updates as one value, never half-written.
// RULE17: Filter restarts on any raw change, reports after stable count.
module lspcb_top #(
    parameter int SS_CYC0 = lspcb_pkg::SS_MS[0] * lspcb_pkg::CLK_KHZ,
    parameter int SS_CYC1 = lspcb_pkg::SS_MS[1] * lspcb_pkg::CLK_KHZ,
    parameter int SS_CYC2 = lspcb_pkg::SS_MS[2] * lspcb_pkg::CLK_KHZ,
    parameter int SS_CYC3 = lspcb_pkg::SS_MS[3] * lspcb_pkg::CLK_KHZ
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [lspcb_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic headroom_cmp_raw,
    input wire logic frame_sync_in,
    input wire logic dim_pwm_out,
    input wire logic soft_start_go,
    output logic cmp_filtered,
    output logic led_short_check,
    output logic boost_down_check,
    output logic [3:0] thermal_dim_gain,
    output logic thermal_dim_active,
    output logic soft_start_active,
    output logic [lspcb_pkg::DIV_W-1:0] slow_div,
    output logic [7:0] loop_coeff,
    output logic div_select_fast,
    output logic loop_enable,
    output lspcb_pkg::lspcb_clk_src_type dim_clk_src,
    output logic frame_rate_mode,
    output logic phase_ref,
    output logic phase_fb,
    output logic dim_counter_reset
);
    typedef enum logic {SS_IDLE, SS_RAMP} lspcb_ss_state_type;

    logic [7:0] filter_gain_q;
    logic [7:0] therm_ss_q;
    logic [7:0] div_upper_q;
    logic [7:0] sync_ctrl_q;
    logic [7:0] loop_cfg_q;
    logic [7:0] sync_type_q;
    logic [31:0] rd_data_q;
    logic [lspcb_pkg::DIV_W-1:0] slow_div_q;
    logic sync_prev_q;
    logic pwm_prev_q;
    logic [3:0] prediv_cnt_q;
    logic [lspcb_pkg::DIV_W-1:0] fb_cnt_q;
    logic phase_ref_q;
    logic phase_fb_q;
    logic cnt_reset_q;
    logic [3:0] gain_out_q;
    logic therm_act_q;
    logic [7:0] coeff_q;
    lspcb_pkg::lspcb_clk_src_type src_q;
    lspcb_ss_state_type ss_state_q;
    logic [lspcb_pkg::SS_CNT_W-1:0] ss_cnt_q;
    logic [lspcb_pkg::SS_CNT_W-1:0] ss_len;
    logic filt_out;

    // Bus decode: zero wait states, unmapped words answer with an error.
    wire logic [7:0] idx = paddr[9:2];
    wire logic aligned = paddr[1:0] == 2'h0 && paddr[11:10] == 2'h0;
    wire logic hit_fg = aligned && idx == lspcb_pkg::IDX_FILTER_GAIN;
    wire logic hit_ts = aligned && idx == lspcb_pkg::IDX_THERM_SS;
    wire logic hit_du = aligned && idx == lspcb_pkg::IDX_DIV_UPPER;
    wire logic hit_sc = aligned && idx == lspcb_pkg::IDX_SYNC_CTRL;
    wire logic hit_lc = aligned && idx == lspcb_pkg::IDX_LOOP_CFG;
    wire logic hit_st = aligned && idx == lspcb_pkg::IDX_SYNC_TYPE;
    wire logic hit_ss = aligned && idx == lspcb_pkg::IDX_STATUS;
    wire logic hit_any = hit_fg || hit_ts || hit_du || hit_sc || hit_lc
        || hit_st || hit_ss;
    wire logic access = psel && penable;
    wire logic wr = access && pwrite && hit_any;
    wire logic setup_rd = psel && !penable && !pwrite;

    assign pready = 1'b1;
    assign pslverr = access && !hit_any;
    assign prdata = rd_data_q;

    wire logic [7:0] status_val = {4'h0, sync_ctrl_q[7], soft_start_active,
        headroom_cmp_raw, filt_out};
    wire logic [7:0] rd_mux =
        hit_fg ? filter_gain_q :
        hit_ts ? therm_ss_q :
        hit_du ? div_upper_q :
        hit_sc ? sync_ctrl_q :
        hit_lc ? loop_cfg_q :
        hit_st ? sync_type_q :
        hit_ss ? status_val : 8'h00;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            filter_gain_q <= lspcb_pkg::RST_FILTER_GAIN;
            therm_ss_q <= lspcb_pkg::RST_THERM_SS;
            div_upper_q <= lspcb_pkg::RST_DIV_UPPER;
            sync_ctrl_q <= lspcb_pkg::RST_SYNC_CTRL;
            loop_cfg_q <= lspcb_pkg::RST_LOOP_CFG;
            sync_type_q <= lspcb_pkg::RST_SYNC_TYPE;
            rd_data_q <= 32'h0000_0000;
        end else begin
            if (wr && hit_fg) filter_gain_q <= pwdata[7:0]; // RULE3
            if (wr && hit_ts) therm_ss_q <= pwdata[7:0];
            if (wr && hit_du) div_upper_q <= pwdata[7:0]; // RULE6
            if (wr && hit_sc) sync_ctrl_q <= pwdata[7:0]; // RULE7
            if (wr && hit_lc) loop_cfg_q <= pwdata[7:0];
            if (wr && hit_st) sync_type_q <= pwdata[7:0];
            if (setup_rd) rd_data_q <= {24'h00_0000, rd_mux};
        end
    end

    // Field views of the control registers.
    lspcb_pkg::lspcb_sync_ctrl_type sync_ctrl;
    lspcb_pkg::lspcb_loop_cfg_type loop_cfg;
    assign sync_ctrl = lspcb_pkg::lspcb_sync_ctrl_type'(sync_ctrl_q);
    assign loop_cfg = lspcb_pkg::lspcb_loop_cfg_type'(loop_cfg_q);
    wire logic [3:0] filt_sel = filter_gain_q[lspcb_pkg::FILT_LSB +: 4];
    wire logic [1:0] ss_sel = therm_ss_q[lspcb_pkg::SS_LSB +: 2];
    wire logic therm_en = therm_ss_q[lspcb_pkg::THERM_EN_BIT];

    // The upper byte is staged; software writes it first and the lower
    // field second, so the live divider only ever takes a whole value.
    wire logic wr_lower = wr && hit_sc;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            slow_div_q <= '0;
        end else if (wr_lower) begin
            slow_div_q <= {div_upper_q, pwdata[4:0]}; // RULE16 RULE6 RULE7
        end
    end
    assign slow_div = slow_div_q;

    lspcb_filter #(
        .LEN_W(lspcb_pkg::FILT_W)
    ) u_filter (
        .clk(clk),
        .rst(rst),
        .raw(headroom_cmp_raw),
        .len(lspcb_pkg::FILT_LEN[filt_sel]), // RULE1
        .filtered_q(filt_out)
    );
    assign cmp_filtered = filt_out;
    assign led_short_check = filt_out; // RULE2
    assign boost_down_check = filt_out; // RULE2

    // Frame-sync edge is taken only while the input is enabled.
    wire logic sync_rise = frame_sync_in && !sync_prev_q;
    wire logic rise_accept = sync_rise && sync_ctrl.enable; // RULE8
    wire logic pre_done = prediv_cnt_q >= loop_cfg.prediv;
    wire logic pwm_rise = dim_pwm_out && !pwm_prev_q;
    wire logic fb_done = fb_cnt_q + 13'h0001 >= slow_div_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_prev_q <= 1'b0;
            pwm_prev_q <= 1'b0;
            prediv_cnt_q <= 4'h0;
            fb_cnt_q <= '0;
            phase_ref_q <= 1'b0;
            phase_fb_q <= 1'b0;
            cnt_reset_q <= 1'b0;
        end else begin
            sync_prev_q <= frame_sync_in;
            pwm_prev_q <= dim_pwm_out;
            phase_ref_q <= rise_accept && pre_done; // RULE14
            if (rise_accept) begin
                prediv_cnt_q <= pre_done ? 4'h0 : prediv_cnt_q + 4'h1;
            end
            cnt_reset_q <= rise_accept && sync_ctrl.cnt_reset; // RULE10
            phase_fb_q <= sync_ctrl.lock && pwm_rise && fb_done; // RULE9
            if (!sync_ctrl.lock) begin
                fb_cnt_q <= '0;
            end else if (pwm_rise) begin
                fb_cnt_q <= fb_done ? '0 : fb_cnt_q + 13'h0001;
            end
        end
    end
    assign phase_ref = phase_ref_q;
    assign phase_fb = phase_fb_q;
    assign dim_counter_reset = cnt_reset_q;

    // Loop configuration as seen by the analog loop and clock mux.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gain_out_q <= 4'h0;
            therm_act_q <= 1'b0;
            coeff_q <= lspcb_pkg::COEFF_BASE;
            src_q <= lspcb_pkg::SRC_OSC;
        end else begin
            gain_out_q <= therm_en ?
                filter_gain_q[lspcb_pkg::GAIN_LSB +: 4] : 4'h0; // RULE3 RULE4
            therm_act_q <= therm_en; // RULE4
            coeff_q <= lspcb_pkg::COEFF_BASE << loop_cfg.coeff_sel; // RULE11
            if (!loop_cfg.loop_en) begin
                src_q <= lspcb_pkg::SRC_OSC; // RULE13
            end else if (sync_ctrl.enable && !loop_cfg.div_fast) begin
                src_q <= lspcb_pkg::SRC_LOOP_SYNC; // RULE13
            end else begin
                src_q <= lspcb_pkg::SRC_LOOP_OSC;
            end
        end
    end
    assign thermal_dim_gain = gain_out_q;
    assign thermal_dim_active = therm_act_q;
    assign loop_coeff = coeff_q;
    assign dim_clk_src = src_q;
    assign div_select_fast = loop_cfg.div_fast; // RULE12
    assign loop_enable = loop_cfg.loop_en; // RULE13
    assign frame_rate_mode = sync_type_q[lspcb_pkg::SYNC_TYPE_BIT]; // RULE15

    // Soft-start timer; the length is sampled when the ramp starts so a
    // register write mid-ramp cannot shorten a ramp already running.
    always_comb begin
        unique case (ss_sel)
            2'h0: ss_len = lspcb_pkg::SS_CNT_W'(SS_CYC0); // RULE5
            2'h1: ss_len = lspcb_pkg::SS_CNT_W'(SS_CYC1);
            2'h2: ss_len = lspcb_pkg::SS_CNT_W'(SS_CYC2);
            2'h3: ss_len = lspcb_pkg::SS_CNT_W'(SS_CYC3);
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ss_state_q <= SS_IDLE;
            ss_cnt_q <= '0;
        end else begin
            unique case (ss_state_q)
                SS_IDLE: begin
                    if (soft_start_go) begin
                        ss_state_q <= SS_RAMP;
                        ss_cnt_q <= ss_len - lspcb_pkg::SS_CNT_W'(1); // RULE5
                    end
                end
                SS_RAMP: begin
                    if (ss_cnt_q == '0) begin
                        ss_state_q <= SS_IDLE;
                    end else begin
                        ss_cnt_q <= ss_cnt_q - lspcb_pkg::SS_CNT_W'(1);
                    end
                end
            endcase
        end
    end
    assign soft_start_active = ss_state_q == SS_RAMP;

    a_thermal_gate_off: assert property ( // RULE4
        @(posedge clk) disable iff (rst)
        !therm_en |=> thermal_dim_gain == 4'h0 && !thermal_dim_active)
        else $error("thermal dimming applied while disabled");

    a_sync_ignored_off: assert property ( // RULE8
        @(posedge clk) disable iff (rst)
        !sync_ctrl.enable |=> !phase_ref && !dim_counter_reset)
        else $error("frame sync acted on while disabled");

    a_counter_reset_edge: assert property ( // RULE10
        @(posedge clk) disable iff (rst)
        sync_ctrl.enable && sync_ctrl.cnt_reset && frame_sync_in
        && !sync_prev_q |=> dim_counter_reset)
        else $error("dimming counter reset missed on sync rise");

    a_div_coherent_load: assert property ( // RULE16
        @(posedge clk) disable iff (rst)
        $changed(slow_div) |-> $past(wr_lower))
        else $error("live divider changed without lower write");

    a_coeff_map_val: assert property ( // RULE11
        @(posedge clk) disable iff (rst)
        ##1 loop_coeff == (8'h10 << $past(loop_cfg_q[7:6])))
        else $error("loop coefficient mismatch");

    a_fb_lock_gate: assert property ( // RULE9
        @(posedge clk) disable iff (rst)
        !sync_ctrl.lock |=> !phase_fb)
        else $error("feedback pulse without lock");

    a_src_osc_direct: assert property ( // RULE13
        @(posedge clk) disable iff (rst)
        !loop_cfg.loop_en |=> dim_clk_src == lspcb_pkg::SRC_OSC)
        else $error("loop clock used while loop disabled");

    a_softstart_hold: assert property ( // RULE5
        @(posedge clk) disable iff (rst)
        !soft_start_active && soft_start_go && ss_sel == 2'h0
        |=> soft_start_active [*8])
        else $error("soft start ended too early");

endmodule : lspcb_top

// File: verif/lspcb_top_tb_top.sv
`timescale 1ns/100ps
module lspcb_top_tb_top;
    localparam int SSC [4] = '{9, 12, 16, 20};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, d;
    logic pready, pslverr, e, cmp_filtered, led_short_check, boost_down_check;
    logic [3:0] thermal_dim_gain;
    logic thermal_dim_active, soft_start_active, div_select_fast, loop_enable;
    logic [12:0] slow_div;
    logic [7:0] loop_coeff;
    lspcb_pkg::lspcb_clk_src_type dim_clk_src;
    logic frame_rate_mode, phase_ref, phase_fb, dim_counter_reset;
    logic raw = 1'b0, fsync = 1'b0, pwm = 1'b0, go = 1'b0;
    int miscompares = 0;
    int tests_run = 0;
    int r, p, f;

    always #20 clk = ~clk;

    lspcb_top #(.SS_CYC0(9), .SS_CYC1(12), .SS_CYC2(16), .SS_CYC3(20)) u_dut (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .headroom_cmp_raw(raw),
        .frame_sync_in(fsync), .dim_pwm_out(pwm), .soft_start_go(go),
        .cmp_filtered(cmp_filtered), .led_short_check(led_short_check),
        .boost_down_check(boost_down_check),
        .thermal_dim_gain(thermal_dim_gain),
        .thermal_dim_active(thermal_dim_active),
        .soft_start_active(soft_start_active), .slow_div(slow_div),
        .loop_coeff(loop_coeff), .div_select_fast(div_select_fast),
        .loop_enable(loop_enable), .dim_clk_src(dim_clk_src),
        .frame_rate_mode(frame_rate_mode), .phase_ref(phase_ref),
        .phase_fb(phase_fb), .dim_counter_reset(dim_counter_reset));

    task end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    task chk(input string name, input logic [31:0] seen,
             input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // The request is held until pready is seen high; the wait is bounded.
    task apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h0, wd};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 16) begin
                miscompares++;
                end_of_test();
            end
            @(posedge clk);
        end
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Derived outputs trail the register by one more clock.
    task settle;
        repeat (2) @(negedge clk);
    endtask : settle

    task filt(input logic [3:0] code);
        int l;
        l = lspcb_pkg::FILT_LEN[code];
        apb(1'b1, 8'h69, {4'h9, code});
        @(posedge clk);
        raw <= 1'b1;
        repeat (3) @(posedge clk);
        raw <= 1'b0;
        @(posedge clk);
        raw <= 1'b1;
        // The count reaches its length one clock before the output moves.
        repeat (l + 1) @(negedge clk);
        chk("filter early", cmp_filtered, 32'h0);
        repeat (1) @(negedge clk);
        chk("filter late", cmp_filtered, 32'h1);
        chk("short check", led_short_check, 32'h1);
        chk("boost down", boost_down_check, 32'h1);
        apb(1'b0, 8'h7F, 8'h00);
        chk("status", d, 32'h3);
        @(posedge clk);
        raw <= 1'b0;
        repeat (l + 6) @(negedge clk);
        chk("filter fall", cmp_filtered, 32'h0);
    endtask : filt

    task ss(input logic [1:0] k);
        int n;
        n = 0;
        apb(1'b1, 8'h6A, {2'b10, k, 4'h0});
        @(posedge clk);
        go <= 1'b1;
        // A second start request mid-ramp must not stretch the ramp.
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            go <= (i == 4);
            @(negedge clk);
            if (soft_start_active === 1'b1) n++;
        end
        chk("soft start length", n, SSC[k]);
    endtask : ss

    task rises(input int n);
        r = 0;
        p = 0;
        f = 0;
        repeat (n) begin
            for (int j = 0; j < 4; j++) begin
                @(posedge clk);
                fsync <= (j == 0);
                pwm <= (j == 0);
                @(negedge clk);
                if (dim_counter_reset === 1'b1) r++;
                if (phase_ref === 1'b1) p++;
                if (phase_fb === 1'b1) f++;
            end
        end
    endtask : rises

    initial begin
        logic [7:0] cfg [3];
        cfg = '{8'hE2, 8'hC2, 8'h02};
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (int i = 32'h69; i <= 32'h6E; i++) begin
            apb(1'b0, 8'(i), 8'h00);
            chk("reset value", d, 32'h0);
        end
        chk("reset coeff", loop_coeff, 32'h10);
        chk("frame rate reset", frame_rate_mode, 32'h0);
        $display("test reset done");
        for (int i = 32'h69; i <= 32'h6E; i++) apb(1'b1, 8'(i), ~8'(i));
        for (int i = 32'h69; i <= 32'h6E; i++) begin
            apb(1'b0, 8'(i), 8'h00);
            chk("readback", d, {24'h0, ~8'(i)});
        end
        settle();
        chk("gain", thermal_dim_gain, 32'h9);
        chk("thermal on", thermal_dim_active, 32'h1);
        chk("divider", slow_div, {8'h94, 5'h13});
        chk("coeff", loop_coeff, 32'h40);
        chk("fast sel", div_select_fast, 32'h0);
        chk("loop on", loop_enable, 32'h1);
        chk("src", dim_clk_src, lspcb_pkg::SRC_LOOP_SYNC);
        chk("sync type", frame_rate_mode, 32'h1);
        apb(1'b1, 8'h70, 8'h55);
        chk("unmapped write", e, 32'h1);
        apb(1'b0, 8'h70, 8'h00);
        chk("unmapped read", {e, d[30:0]}, 32'h80000000);
        $display("test registers done");
        apb(1'b1, 8'h6A, 8'h15);
        apb(1'b1, 8'h6B, 8'hA5);
        settle();
        chk("thermal off", thermal_dim_gain, 32'h0);
        chk("thermal flag off", thermal_dim_active, 32'h0);
        chk("half write", slow_div, {8'h94, 5'h13});
        apb(1'b1, 8'h6C, 8'h13);
        settle();
        chk("full write", slow_div, {8'hA5, 5'h13});
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, 8'h6D, {2'(k), 6'h30});
            settle();
            chk("coeff", loop_coeff, 32'h10 << k);
            chk("fast sel", div_select_fast, 32'h1);
            chk("src", dim_clk_src, lspcb_pkg::SRC_LOOP_OSC);
        end
        $display("test dividers done");
        apb(1'b1, 8'h6B, 8'h00);
        apb(1'b1, 8'h6D, 8'h01);
        for (int c = 0; c < 3; c++) begin
            apb(1'b1, 8'h6C, cfg[c]);
            settle();
            rises(4);
            chk("counter resets", r, (c == 0) ? 4 : 0);
            chk("phase ref", p, (c < 2) ? 2 : 0);
            chk("phase fb", f, (c < 2) ? 2 : 0);
        end
        chk("src off", dim_clk_src, lspcb_pkg::SRC_OSC);
        chk("loop off", loop_enable, 32'h0);
        $display("test sync done");
        filt(4'h0);
        filt(4'h7);
        filt(4'hF);
        $display("test filter done");
        for (int k = 0; k < 4; k++) ss(2'(k));
        $display("test soft start done");
        end_of_test();
    end
endmodule : lspcb_top_tb_top
